// *** logic/adcrc_cfg.svh ***
// timing counts, code values and scaling for the result coding block
`ifndef ADCRC_CFG_SVH
`define ADCRC_CFG_SVH

// master clock and word rate at the top of the master clock range
`define ADCRC_MCLK_HZ 4096000
`define ADCRC_WORD_RATE_HZ 4000

// master clock cycles between input samples
`define ADCRC_SAMPLE_DIV 256
// master clock periods allowed for the input to settle after a sample
`define ADCRC_SETTLE_CYC 6'h3E
// filter corner sits at the master clock divided by this ratio
`define ADCRC_FILT_RATIO 409600

// input level unit is vref/131072: one unipolar lsb is 2 units, one bipolar lsb is 4
`define ADCRC_UNI_SHIFT 1
`define ADCRC_BIP_SHIFT 2
`define ADCRC_UNI_HALF 21'sh00001
`define ADCRC_BIP_HALF 21'sh00002

`define ADCRC_MIDSCALE 21'sh08000
`define ADCRC_CODE_MAX 21'sh0FFFF
`define ADCRC_CODE_ZERO 16'h0000
`define ADCRC_CODE_FULL 16'hFFFF
`define ADCRC_CODE_MID 16'h8000
`define ADCRC_CODE_BELOW_MID 16'h7FFF

`endif

// *** logic/adcrc_pkg.sv ***
// types shared by the result coding block
`default_nettype none
package adcrc_pkg;

    // gray order along idle -> settle -> track -> settle
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_SETTLE = 2'b01,
        PH_TRACK = 2'b11
    } adcrc_phase_t;

endpackage
`default_nettype wire

// *** logic/adcrc_fmt.sv ***
// maps an averaged input level to a 16-bit unipolar or offset binary code
`timescale 1ns/1ps
`default_nettype none
`include "adcrc_cfg.svh"

module adcrc_fmt (
    input wire logic signed [18:0] level_i, // averaged level, vref/131072 per unit
    input wire logic bipolar_i,             // 1 selects the bipolar span
    output logic [15:0] code_o              // saturated result code
);
    logic signed [20:0] ext;
    logic signed [20:0] uni;
    logic signed [20:0] bip;
    logic signed [20:0] pick;

    always_comb begin
        ext = {{2{level_i[18]}}, level_i};
        // adding half an lsb before the shift puts code edges at half-lsb points
        uni = (ext + `ADCRC_UNI_HALF) >>> `ADCRC_UNI_SHIFT; // RL6 RL8
        bip = ((ext + `ADCRC_BIP_HALF) >>> `ADCRC_BIP_SHIFT) + `ADCRC_MIDSCALE; // RL5 RL6 RL8
        pick = bipolar_i ? bip : uni; // RL4 RL5
        if (pick < 21'sh00000) begin
            code_o = `ADCRC_CODE_ZERO; // RL7
        end else if (pick > `ADCRC_CODE_MAX) begin
            code_o = `ADCRC_CODE_FULL; // RL7
        end else begin
            code_o = pick[15:0];
        end
    end

endmodule
`default_nettype wire

// *** logic/adcrc_core.sv ***
// sampling timing, word averaging and atomic result refresh of the converter
//
// Notes on behaviour
// RL1 - sampling runs by itself; there is no start request input.
// RL2 - a 16-bit result is refreshed at 4 kHz; readable any time.
// RL3 - every rate is counted from the master clock, external or crystal.
// RL4 - polarity select low gives a 0 to +vref unipolar span; host holds it static.
// RL5 - polarity select high gives a bipolar -vref to +vref span.
// RL6 - unipolar codes straight binary; bipolar offset binary, zero at 8000.
// RL7 - one code per lsb; codes clamp at all zeros and all ones.
// RL8 - code edges at half-lsb points; just below bipolar zero gives 7FFF.
// RL9 - one sample every 256 master clocks, then 62 periods of settling.
// RL10 - filter corner is the master clock over 409600; the code only averages the 4 samples of each word.
// RL11 - the result word changes in one cycle, never piecewise.
`timescale 1ns/1ps
`default_nettype none
`include "adcrc_cfg.svh"

module adcrc_core (
    input wire logic clk_i,                 // system clock, 250 MHz
    input wire logic arst_n_i,              // asynchronous reset, active low
    input wire logic master_clock_in_i,     // master clock pin or crystal node
    input wire logic polarity_select_i,     // pin: 1 bipolar, 0 unipolar
    input wire logic signed [18:0] ain_i,   // input level from the modulator path
    output logic crystal_drive_out_o,       // inverted master clock to the crystal
    output logic sample_o,                  // one-cycle pulse per input sample
    output logic settle_o,                  // high while the input settles
    output logic [15:0] result_o,           // latest result word
    output logic result_update_o,           // one-cycle pulse when result_o changes
    output logic result_seq_o               // toggles on every refresh
);
    localparam int WORD_SAMPLES = `ADCRC_MCLK_HZ / (`ADCRC_SAMPLE_DIV * `ADCRC_WORD_RATE_HZ);
    localparam logic [1:0] LAST_SAMPLE = 2'(WORD_SAMPLES - 1);

    // reset release through two flip-flops
    logic rst_q1;
    logic rst_n;
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_q1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n <= rst_q1;
        end
    end

    // pin synchronisers; the third master stage only feeds the edge detector
    logic mclk_s1;
    logic mclk_s2;
    logic mclk_s3;
    logic pol_s1;
    logic pol_s2;
    // a pin already high at reset release is not an edge; a fall must be seen before the first rise counts
    logic mclk_armed;
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            mclk_s1 <= 1'b0;
            mclk_s2 <= 1'b0;
            mclk_s3 <= 1'b0;
            pol_s1 <= 1'b0;
            pol_s2 <= 1'b0;
            mclk_armed <= 1'b0;
        end else begin
            mclk_s1 <= master_clock_in_i;
            mclk_s2 <= mclk_s1;
            mclk_s3 <= mclk_s2;
            pol_s1 <= polarity_select_i;
            pol_s2 <= pol_s1;
            mclk_armed <= mclk_armed | (mclk_s3 & ~mclk_s2);
        end
    end

    logic tick;
    assign tick = mclk_s2 & ~mclk_s3 & mclk_armed; // RL3

    adcrc_pkg::adcrc_phase_t phase;
    adcrc_pkg::adcrc_phase_t next_phase;
    logic [7:0] div_cnt;
    logic [7:0] next_div_cnt;
    logic [5:0] set_cnt;
    logic [5:0] next_set_cnt;
    logic [1:0] smp_cnt;
    logic [1:0] next_smp_cnt;
    logic signed [20:0] acc;
    logic signed [20:0] next_acc;
    logic signed [20:0] sum_w;
    logic signed [18:0] avg_w;
    logic [15:0] code_w;
    logic next_crystal;
    logic next_sample;
    logic next_settle;
    logic [15:0] next_result;
    logic next_update;
    logic next_seq;
    logic take;

    assign sum_w = acc + {{2{ain_i[18]}}, ain_i};
    // boxcar over one word; dividing by a power of two keeps the ratio fixed
    assign avg_w = sum_w[20:2]; // RL10

    adcrc_fmt u_fmt (
        .level_i(avg_w),
        .bipolar_i(pol_s2),
        .code_o(code_w)
    );

    always_comb begin
        next_phase = phase;
        next_div_cnt = div_cnt;
        next_set_cnt = set_cnt;
        next_smp_cnt = smp_cnt;
        next_acc = acc;
        next_result = result_o;
        next_update = 1'b0;
        next_seq = result_seq_o;
        next_sample = 1'b0;
        next_crystal = ~mclk_s2; // RL3
        take = tick && (div_cnt == 8'h00); // RL1 RL9
        if (tick) begin
            next_div_cnt = div_cnt + 8'h01; // RL9
            if (set_cnt != 6'h00) begin
                next_set_cnt = set_cnt - 6'h01;
            end
        end
        if (take) begin
            next_sample = 1'b1;
            next_set_cnt = `ADCRC_SETTLE_CYC; // RL9
            if (smp_cnt == LAST_SAMPLE) begin
                // whole word is loaded in one edge so a read never mixes results
                next_result = code_w; // RL2 RL11
                next_update = 1'b1;
                next_seq = ~result_seq_o;
                next_acc = 21'sh00000;
                next_smp_cnt = 2'h0;
            end else begin
                next_acc = sum_w;
                next_smp_cnt = smp_cnt + 2'h1;
            end
        end
        next_settle = (next_set_cnt != 6'h00);
        case (phase)
            adcrc_pkg::PH_IDLE: begin
                if (take) begin
                    next_phase = adcrc_pkg::PH_SETTLE;
                end
            end
            adcrc_pkg::PH_SETTLE: begin
                if (!next_settle) begin
                    next_phase = adcrc_pkg::PH_TRACK;
                end
            end
            adcrc_pkg::PH_TRACK: begin
                if (take) begin
                    next_phase = adcrc_pkg::PH_SETTLE;
                end
            end
            default: begin
                next_phase = adcrc_pkg::PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            phase <= adcrc_pkg::PH_IDLE;
            div_cnt <= 8'h00;
            set_cnt <= 6'h00;
            smp_cnt <= 2'h0;
            acc <= 21'sh00000;
            crystal_drive_out_o <= 1'b1;
            sample_o <= 1'b0;
            settle_o <= 1'b0;
            result_o <= `ADCRC_CODE_ZERO;
            result_update_o <= 1'b0;
            result_seq_o <= 1'b0;
        end else begin
            phase <= next_phase;
            div_cnt <= next_div_cnt;
            set_cnt <= next_set_cnt;
            smp_cnt <= next_smp_cnt;
            acc <= next_acc;
            crystal_drive_out_o <= next_crystal;
            sample_o <= next_sample;
            settle_o <= next_settle;
            result_o <= next_result;
            result_update_o <= next_update;
            result_seq_o <= next_seq;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n);

    sequence s_take;
        sample_o && (div_cnt == 8'h01) && (set_cnt == `ADCRC_SETTLE_CYC);
    endsequence

    sequence s_refresh;
        result_update_o && sample_o && (smp_cnt == 2'h0);
    endsequence

    property p_sample_timing;
        sample_o |-> s_take;
    endproperty
    a_sample_timing: assert property (p_sample_timing) else $error("sample not at divider wrap"); // RL9

    property p_settle_hold;
        sample_o |-> settle_o [*8];
    endproperty
    a_settle_hold: assert property (p_settle_hold) else $error("settle window ended early"); // RL9

    property p_settle_end;
        $fell(settle_o) |-> (set_cnt == 6'h00) && ($past(set_cnt) == 6'h01);
    endproperty
    a_settle_end: assert property (p_settle_end) else $error("settle window wrong length"); // RL9

    property p_refresh;
        result_update_o |-> s_refresh ##0 ($past(smp_cnt) == LAST_SAMPLE);
    endproperty
    a_refresh: assert property (p_refresh) else $error("refresh not on last sample of word"); // RL2

    property p_atomic;
        !result_update_o |-> $stable(result_o) && $stable(result_seq_o);
    endproperty
    a_atomic: assert property (p_atomic) else $error("result changed outside refresh"); // RL11

    property p_bip_mid;
        result_update_o && $past(pol_s2) && ($past(avg_w) == 19'sh00000) |-> result_o == `ADCRC_CODE_MID;
    endproperty
    a_bip_mid: assert property (p_bip_mid) else $error("bipolar zero not midscale"); // RL6

    property p_bip_below;
        result_update_o && $past(pol_s2) && ($past(avg_w) == -19'sh00003) |-> result_o == `ADCRC_CODE_BELOW_MID;
    endproperty
    a_bip_below: assert property (p_bip_below) else $error("bipolar half-lsb edge wrong"); // RL8

    property p_uni_floor;
        result_update_o && !$past(pol_s2) && ($past(avg_w) < 19'sh00000) |-> result_o == `ADCRC_CODE_ZERO;
    endproperty
    a_uni_floor: assert property (p_uni_floor) else $error("unipolar code not clamped at zero"); // RL4 RL7

    property p_crystal;
        crystal_drive_out_o == !$past(mclk_s2);
    endproperty
    a_crystal: assert property (p_crystal) else $error("crystal drive not inverse of master"); // RL3

endmodule
`default_nettype wire

// *** tb/adcrc_host_model.sv ***
// far-side model: master clock source and a host reading the result word
`timescale 1ns/1ps
`default_nettype none
module adcrc_host_model #(
    parameter realtime HALF_NS = 12.0 // 3 system clocks per master level
) (
    input wire logic clk_i,            // system clock
    input wire logic arst_n_i,         // bench reset, active low
    input wire logic [15:0] result_i,  // result word seen by the host
    input wire logic result_update_i,  // refresh pulse
    output logic master_clock_o,       // free-running master clock
    output var int torn_o              // reads that changed without a refresh
);
    logic [15:0] held;
    initial begin
        master_clock_o = 1'b0;
        torn_o = 0;
        held = 16'h0000;
        // offset keeps master edges away from system clock edges
        #1.3;
        forever #(HALF_NS) master_clock_o = ~master_clock_o;
    end
    // the host reads every cycle, unaware of the refresh timing
    always @(posedge clk_i) begin
        if (arst_n_i && !result_update_i && result_i !== held) torn_o <= torn_o + 1;
        held <= result_i;
    end
endmodule
`default_nettype wire

// *** tb/adc_result_coding_timing_tb.sv ***
// self-checking bench for result coding and sampling timing
`timescale 1ns/1ps
`default_nettype none
module adc_result_coding_timing_tb;
    typedef struct {logic bip; logic signed [18:0] lvl; logic [15:0] code;} adcrc_row_t;
    logic clk_i, arst_n_i, master, polarity, crystal, sample, settle, upd, seq;
    logic signed [18:0] ain;
    logic [15:0] result;
    int bad_count = 0;
    int compares = 0;
    int cyc = 0;
    int torn, s_gap, u_gap, s_len;
    logic seq_prev;
    adcrc_row_t rows [10] = '{
        '{1'b0, 19'sh00000, 16'h0000}, '{1'b0, 19'sh00002, 16'h0001},
        '{1'b0, 19'sh10000, 16'h8000}, '{1'b0, 19'sh20000, 16'hFFFF},
        '{1'b0, -19'sh00005, 16'h0000}, '{1'b1, 19'sh00000, 16'h8000},
        '{1'b1, -19'sh00003, 16'h7FFF}, '{1'b1, 19'sh00004, 16'h8001},
        '{1'b1, 19'sh20000, 16'hFFFF}, '{1'b1, -19'sh20000, 16'h0000}};

    adcrc_core dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .master_clock_in_i(master),
        .polarity_select_i(polarity), .ain_i(ain), .crystal_drive_out_o(crystal),
        .sample_o(sample), .settle_o(settle), .result_o(result),
        .result_update_o(upd), .result_seq_o(seq));
    adcrc_host_model host (.clk_i(clk_i), .arst_n_i(arst_n_i), .result_i(result),
        .result_update_i(upd), .master_clock_o(master), .torn_o(torn));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out;
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // bounded wait, ends at the falling edge where the refresh pulse shows
    task automatic wait_update;
        int n;
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (upd !== 1'b1 && n < 7000);
        check(upd, 1'b1);
    endtask

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 85000) begin
            bad_count++;
            close_out();
        end
    end

    // timing monitor, restarted by every reset
    always @(negedge clk_i) begin
        if (arst_n_i !== 1'b1) begin
            s_gap = 0;
            u_gap = 0;
            s_len = 0;
            seq_prev = 1'b0;
        end else begin
            if (sample === 1'b1) begin
                check(settle, 1'b1);
                if (s_gap != 0) check(s_gap, 1536);
                s_gap = 1;
            end else if (s_gap != 0) s_gap++;
            if (upd === 1'b1) begin
                check(sample, 1'b1);
                check(seq, !seq_prev);
                if (u_gap != 0) check(u_gap, 6144);
                u_gap = 1;
            end else if (u_gap != 0) u_gap++;
            if (settle === 1'b1) s_len++;
            else if (s_len != 0) begin
                check(s_len, 372);
                s_len = 0;
            end
            seq_prev = seq;
        end
    end

    initial begin
        arst_n_i = 1'b0;
        polarity = 1'b0;
        ain = 19'sh00000;
        repeat (10) @(negedge clk_i);
        check({result, upd, sample, settle, crystal}, 20'h00001);
        repeat (10) @(posedge clk_i);
        arst_n_i <= 1'b1;
        wait_update();
        for (int i = 0; i < 10; i++) begin
            @(posedge clk_i);
            polarity <= rows[i].bip;
            ain <= rows[i].lvl;
            wait_update();
            check(result, rows[i].code);
            $display("row %0d done", i);
        end
        // reset in mid-run with a new level; the first word after it holds that level only
        @(posedge clk_i);
        arst_n_i <= 1'b0;
        ain <= 19'sh00004;
        repeat (3) @(negedge clk_i);
        check({result, upd, sample, settle, crystal}, 20'h00001);
        @(posedge clk_i);
        arst_n_i <= 1'b1;
        wait_update();
        check(result, 16'h8001);
        check(torn, 0);
        $display("reset test done");
        close_out();
    end
endmodule
`default_nettype wire
